/* File: verilog/axis_card_counter.sv */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
// Operation
// [R1] host reads each active axis position once to start its discriminator
// [R2] in latched mode host writes a status byte to arm the watchdog
// [R3] every position read retriggers the read watchdog
// [R4] host reads captured values during init to reset capture logic
// [R5] writing capture_arm_bit as 1 in any status arms a capture
// [R6] probe trigger while armed freezes positions of all axes
// [R7] reading an axis captured value releases its frozen position
// [R8] position read while capture unread returns capture, no release
// [R9] reading the captured value clears capture_ready_bit
// [R10] host reads unneeded captured values too, to release positions
// [R11] after capture, re-arming needs at least one captured value read
// [R12] new capture leaves unread captured values unchanged
// [R13] reading a captured value does not retrigger the watchdog
// [R14] reading any captured value before trigger cancels armed capture
// [R15] probe polarity selectable; active level fires at once when armed
// [R16] watchdog expiry clears set value only when the option is on
// [R17] set value is a 16-bit signed code passed through unchanged
// [R18] counter mode counts track a pulses; position read clears it
// [R19] track b change stops counter; resumes on enabling level plus reset
// [R20] zero pulse resets the counter in counter mode
// [R21] host rereads position after reference point and discards old one
// [R22] position counter is 16 bits, up/down, wraps without carry
// [R23] a normal position read leaves the counter unchanged
// [R24] watchdog_expired_bit is the top bit of each status byte
// [R25] discriminator counts one, two or four per quadrature cycle
module axis_card_counter #(
  parameter int unsigned WDOG_CYCLES = axis_card_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic [axis_card_pkg::ADDR_W-1:0] ADDR,
  input wire logic [axis_card_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [axis_card_pkg::DATA_W-1:0] RDATA,
  // encoder pins
  input wire logic [axis_card_pkg::AXES-1:0] TRACK_A,
  input wire logic [axis_card_pkg::AXES-1:0] TRACK_B,
  input wire logic [axis_card_pkg::AXES-1:0] ZERO_PULSE,
  input wire logic TOUCH_PROBE_INPUT,
  // jumper straps
  input wire logic [axis_card_pkg::AXES-1:0][1:0] EVAL_MODE,
  input wire logic PROBE_FALLING,
  input wire logic WDOG_CLEARS_SET,
  input wire logic WDOG_LATCHED,
  // outputs
  output logic [axis_card_pkg::AXES-1:0][axis_card_pkg::DATA_W-1:0] SET_VALUE,
  output logic WDOG_EXPIRED
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [axis_card_pkg::SYNC_W-1:0] meta_q, meta_d;
  logic [axis_card_pkg::SYNC_W-1:0] sync_q, sync_d;

  always_comb begin
    meta_d = {WDOG_LATCHED, WDOG_CLEARS_SET, PROBE_FALLING, EVAL_MODE,
              TOUCH_PROBE_INPUT, ZERO_PULSE, TRACK_B, TRACK_A};
    sync_d = meta_q;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  logic probe_active, wd_clear_opt, wd_latched;

  // level, not edge: an already active probe fires on arming
  assign probe_active = sync_q[axis_card_pkg::SY_PROBE] ^
                        sync_q[axis_card_pkg::SY_FALL]; // see [R15]
  assign wd_clear_opt = sync_q[axis_card_pkg::SY_WDCLR];
  assign wd_latched = sync_q[axis_card_pkg::SY_WDLAT];

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [1:0] fn;
  logic [1:0] sel;
  logic [axis_card_pkg::AXES-1:0] rd_pos, rd_cap, wr_stat, wr_set;
  logic any_rd_pos, any_rd_cap, any_wr_stat, arm_req;

  assign fn = ADDR[axis_card_pkg::FN_LSB +: 2];
  assign sel = ADDR[axis_card_pkg::AXIS_LSB +: 2];
  assign any_rd_pos = RD & (fn == axis_card_pkg::FN_ACTUAL);
  assign any_rd_cap = RD & (fn == axis_card_pkg::FN_MEASURE);
  assign any_wr_stat = WR & (fn == axis_card_pkg::FN_STATUS);
  assign arm_req = any_wr_stat &
                   WDATA[axis_card_pkg::CAPTURE_ARM_BIT]; // see [R5]

  always_comb begin
    rd_pos = '0;
    rd_cap = '0;
    wr_stat = '0;
    wr_set = '0;
    rd_pos[sel] = any_rd_pos;
    rd_cap[sel] = any_rd_cap;
    wr_stat[sel] = any_wr_stat;
    wr_set[sel] = WR & (fn == axis_card_pkg::FN_SET);
  end

  // ----------------------------------------
  // read watchdog
  // ----------------------------------------
  logic wd_expired;

  // captured-value reads are left out of the retrigger
  read_watchdog #(
    .CYCLES(WDOG_CYCLES)
  ) u_watchdog (
    .clk(CLK),
    .rst_n(RST_N),
    .retrigger(any_rd_pos), // see [R3] see [R13]
    .rearm(any_wr_stat), // see [R2]
    .latched(wd_latched),
    .expired(wd_expired)
  );

  assign WDOG_EXPIRED = wd_expired;

  // ----------------------------------------
  // capture sequence
  // ----------------------------------------
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_ARMED,
    CAP_DONE
  } cap_state_type;

  cap_state_type cap_state_q, cap_state_d;
  logic fire;

  always_comb begin
    cap_state_d = cap_state_q;
    fire = 1'b0;
    unique case (cap_state_q)
      CAP_IDLE: begin
        if (arm_req && !any_rd_cap) begin // see [R5]
          cap_state_d = CAP_ARMED;
        end
      end
      CAP_ARMED: begin
        // a captured-value read wins over a probe in the same cycle
        if (any_rd_cap) begin // see [R14] see [R4]
          cap_state_d = CAP_IDLE;
        end else if (probe_active) begin // see [R6] see [R15]
          cap_state_d = CAP_DONE;
          fire = 1'b1;
        end
      end
      CAP_DONE: begin
        // arming is ignored until a captured value has been read
        if (any_rd_cap) begin // see [R11]
          cap_state_d = CAP_IDLE;
        end
      end
      default: begin
        cap_state_d = CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_state_q <= CAP_IDLE;
    end else begin
      cap_state_q <= cap_state_d;
    end
  end

  // ----------------------------------------
  // per-axis counters
  // ----------------------------------------
  axis_card_pkg::count_type count_q [axis_card_pkg::AXES];
  axis_card_pkg::count_type cap_q [axis_card_pkg::AXES];
  logic [axis_card_pkg::DATA_W-1:0] set_q [axis_card_pkg::AXES];
  logic [axis_card_pkg::AXES-1:0] ready_q, ref_act_q, ref_done_q;

  genvar i;
  generate
    for (i = 0; i < axis_card_pkg::AXES; i++) begin : g_axis
      quad_if qi ();
      axis_card_pkg::count_type count_d, cap_d;
      logic [axis_card_pkg::DATA_W-1:0] set_d;
      logic ready_d, ref_act_d, ref_done_d;
      logic init_q, init_d, stop_q, stop_d;
      logic zprev_q, zprev_d, bprev_q, bprev_d;
      logic z, b, zero_evt, b_chg, clr;

      assign z = sync_q[axis_card_pkg::SY_Z + i];
      assign b = sync_q[axis_card_pkg::SY_B + i];
      assign qi.a = sync_q[axis_card_pkg::SY_A + i];
      assign qi.b = b;
      assign qi.mode = axis_card_pkg::eval_mode_type'(
        sync_q[axis_card_pkg::SY_MODE + 2 * i +: 2]);

      quad_decoder u_dec (
        .clk(CLK),
        .rst_n(RST_N),
        .q(qi)
      );

      always_comb begin
        count_d = count_q[i];
        cap_d = cap_q[i];
        set_d = set_q[i];
        ready_d = ready_q[i];
        ref_act_d = ref_act_q[i];
        ref_done_d = ref_done_q[i];
        init_d = init_q | rd_pos[i]; // see [R1]
        stop_d = stop_q;
        zprev_d = z;
        bprev_d = b;
        zero_evt = z & ~zprev_q;
        b_chg = b ^ bprev_q;
        clr = (rd_pos[i] & ~ready_q[i]) | zero_evt; // see [R18] see [R20]
        if (qi.mode == axis_card_pkg::EVAL_COUNTER) begin
          if (b_chg) begin
            stop_d = 1'b1; // see [R19]
          end else if (clr && b) begin
            stop_d = 1'b0; // see [R19]
          end
          if (clr) begin
            count_d = axis_card_pkg::COUNT_RESET;
          end else if (qi.up && !stop_q) begin
            count_d = count_q[i] + 1'b1; // see [R22]
          end
        end else if (ref_act_q[i] && zero_evt) begin
          count_d = axis_card_pkg::COUNT_RESET;
          ref_act_d = 1'b0;
          ref_done_d = 1'b1;
        end else if (init_q) begin
          // reads alone never touch the count here
          if (qi.up) begin // see [R23]
            count_d = count_q[i] + 1'b1; // see [R22]
          end else if (qi.down) begin
            count_d = count_q[i] - 1'b1; // see [R22]
          end
        end
        if (wr_stat[i] && WDATA[axis_card_pkg::REF_ACTIVE_BIT]) begin
          ref_act_d = 1'b1;
          ref_done_d = 1'b0;
        end
        if (rd_cap[i]) begin
          ready_d = 1'b0; // see [R7] see [R9]
        end else if (fire && !ready_q[i]) begin
          cap_d = count_q[i]; // see [R6] see [R12]
          ready_d = 1'b1;
        end
        if (wd_expired && wd_clear_opt) begin
          set_d = axis_card_pkg::SET_RESET; // see [R16]
        end else if (wr_set[i]) begin
          set_d = WDATA; // see [R17]
        end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          count_q[i] <= axis_card_pkg::COUNT_RESET;
          cap_q[i] <= axis_card_pkg::COUNT_RESET;
          set_q[i] <= axis_card_pkg::SET_RESET;
          ready_q[i] <= 1'b0;
          ref_act_q[i] <= 1'b0;
          ref_done_q[i] <= 1'b0;
          init_q <= 1'b0;
          stop_q <= 1'b0;
          zprev_q <= 1'b0;
          bprev_q <= 1'b0;
        end else begin
          count_q[i] <= count_d;
          cap_q[i] <= cap_d;
          set_q[i] <= set_d;
          ready_q[i] <= ready_d;
          ref_act_q[i] <= ref_act_d;
          ref_done_q[i] <= ref_done_d;
          init_q <= init_d;
          stop_q <= stop_d;
          zprev_q <= zprev_d;
          bprev_q <= bprev_d;
        end
      end

      assign SET_VALUE[i] = set_q[i];
    end
  endgenerate

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [axis_card_pkg::DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = axis_card_pkg::READ_IDLE;
    if (RD) begin
      unique case (fn)
        axis_card_pkg::FN_STATUS: begin
          rdata_d[axis_card_pkg::REF_REACHED_BIT] = ref_done_q[sel];
          rdata_d[axis_card_pkg::CAPTURE_READY_BIT] = ready_q[sel];
          rdata_d[axis_card_pkg::WATCHDOG_EXPIRED_BIT] =
            wd_expired; // see [R24]
        end
        axis_card_pkg::FN_ACTUAL: begin
          // frozen while the capture is unread
          if (ready_q[sel]) begin // see [R8]
            rdata_d = cap_q[sel];
          end else begin
            rdata_d = count_q[sel];
          end
        end
        axis_card_pkg::FN_SET: begin
          rdata_d = axis_card_pkg::READ_IDLE;
        end
        axis_card_pkg::FN_MEASURE: begin
          rdata_d = cap_q[sel];
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= axis_card_pkg::READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

endmodule

/* File: shared/axis_card_pkg.sv */
package axis_card_pkg;

  // ----------------------------------------
  // card geometry
  // ----------------------------------------
  localparam int AXES = 4;
  localparam int CNT_W = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int AXIS_LSB = 3;
  localparam int FN_LSB = 1;

  typedef logic [CNT_W-1:0] count_type;

  // function select, address bits 2..1
  localparam logic [1:0] FN_STATUS = 2'h0;
  localparam logic [1:0] FN_ACTUAL = 2'h1;
  localparam logic [1:0] FN_SET = 2'h2;
  localparam logic [1:0] FN_MEASURE = 2'h3;

  // ----------------------------------------
  // status byte layout
  // ----------------------------------------
  localparam int REF_ACTIVE_BIT = 0;
  localparam int REF_REACHED_BIT = 1;
  localparam int CAPTURE_ARM_BIT = 2;
  localparam int CAPTURE_READY_BIT = 3;
  localparam int WATCHDOG_EXPIRED_BIT = 7;

  localparam count_type COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SET_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

  // evaluation multiplicity strapped per axis
  typedef enum logic [1:0] {
    EVAL_FOUR,
    EVAL_DOUBLE,
    EVAL_SINGLE,
    EVAL_COUNTER
  } eval_mode_type;

  // ----------------------------------------
  // pin synchroniser vector positions
  // ----------------------------------------
  localparam int SY_A = 0;
  localparam int SY_B = SY_A + AXES;
  localparam int SY_Z = SY_B + AXES;
  localparam int SY_PROBE = SY_Z + AXES;
  localparam int SY_MODE = SY_PROBE + 1;
  localparam int SY_FALL = SY_MODE + 2 * AXES;
  localparam int SY_WDCLR = SY_FALL + 1;
  localparam int SY_WDLAT = SY_WDCLR + 1;
  localparam int SYNC_W = SY_WDLAT + 1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned WDOG_TIME_MS = 20;
  localparam int unsigned WDOG_CYCLES = WDOG_TIME_MS * (CLK_HZ / 1000);

endpackage

/* File: shared/quad_if.sv */
`timescale 1ns/1ps
interface quad_if;
  logic a;
  logic b;
  axis_card_pkg::eval_mode_type mode;
  logic up;
  logic down;

  modport decoder (input a, input b, input mode, output up, output down);
  modport owner (output a, output b, output mode, input up, input down);
endinterface

/* File: verilog/quad_decoder.sv */
`timescale 1ns/1ps
module quad_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised tracks and count strobes
  quad_if.decoder q
);

  logic a_q, a_d, b_q, b_d;
  logic a_chg, b_chg;

  always_comb begin
    a_d = q.a;
    b_d = q.b;
    a_chg = q.a ^ a_q;
    b_chg = q.b ^ b_q;
    q.up = 1'b0;
    q.down = 1'b0;
    unique case (q.mode)
      axis_card_pkg::EVAL_FOUR: begin // see [R25]
        q.up = (a_chg & (q.a != q.b)) | (b_chg & (q.a == q.b));
        q.down = (a_chg & (q.a == q.b)) | (b_chg & (q.a != q.b));
      end
      axis_card_pkg::EVAL_DOUBLE: begin // see [R25]
        q.up = a_chg & (q.a != q.b);
        q.down = a_chg & (q.a == q.b);
      end
      axis_card_pkg::EVAL_SINGLE: begin // see [R25]
        q.up = a_chg & q.a & ~q.b;
        q.down = a_chg & q.a & q.b;
      end
      axis_card_pkg::EVAL_COUNTER: begin
        // plain pulse count on rising track a
        q.up = a_chg & q.a; // see [R18]
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
    end
  end

endmodule

/* File: verilog/read_watchdog.sv */
`timescale 1ns/1ps
module read_watchdog #(
  parameter int unsigned CYCLES = axis_card_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic retrigger,
  input wire logic rearm,
  input wire logic latched,
  // state
  output logic expired
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_q, count_d;
  logic expired_q, expired_d;
  logic armed_q, armed_d;
  logic timeout;

  always_comb begin
    count_d = count_q;
    expired_d = expired_q;
    armed_d = armed_q;
    timeout = (count_q == LAST) & ~retrigger;
    if (retrigger || rearm) begin
      count_d = '0;
    end else if (count_q != LAST) begin
      count_d = count_q + 1'b1;
    end
    if (latched) begin
      // stored expiry: only a status write clears it and arms
      if (rearm) begin // see [R2]
        armed_d = 1'b1;
        expired_d = 1'b0;
      end else if (armed_q && timeout) begin
        expired_d = 1'b1;
      end
    end else begin
      expired_d = timeout;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      expired_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      count_q <= count_d;
      expired_q <= expired_d;
      armed_q <= armed_d;
    end
  end

  assign expired = expired_q;

endmodule

/* File: sim/axis_card_counter_asserts.sv */
`timescale 1ns/1ps
module axis_card_counter_asserts #(
  parameter int unsigned WDOG_CYCLES = axis_card_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic [axis_card_pkg::ADDR_W-1:0] ADDR,
  input wire logic [axis_card_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [axis_card_pkg::DATA_W-1:0] RDATA,
  // straps and outputs
  input wire logic WDOG_CLEARS_SET,
  input wire logic WDOG_LATCHED,
  input wire logic [axis_card_pkg::AXES-1:0]
    [axis_card_pkg::DATA_W-1:0] SET_VALUE,
  input wire logic WDOG_EXPIRED
);
  // ----------------------------------------
  // cycles since the last position read or status write
  // ----------------------------------------
  logic [31:0] idle_q;
  logic [31:0] idle_d;
  logic pos_rd;
  logic st_wr;
  logic [1:0] fn;

  assign fn = ADDR[2:1];
  assign pos_rd = RD && fn == axis_card_pkg::FN_ACTUAL;
  assign st_wr = WR && fn == axis_card_pkg::FN_STATUS;

  // saturates so a long idle stretch cannot wrap back to "fresh"
  always_comb begin
    idle_d = idle_q;
    // a status write restarts the watchdog count as well
    if (pos_rd || st_wr) begin
      idle_d = '0;
    end else if (idle_q < WDOG_CYCLES + 8) begin
      idle_d = idle_q + 32'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_d;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_STATUS_LAYOUT: assert property (
    RD && fn == axis_card_pkg::FN_STATUS |=> (RDATA & 16'hff75) == '0)
    else $error("status read shows bits outside its layout");
  AST_STATUS_EXPIRED: assert property (
    RD && fn == axis_card_pkg::FN_STATUS |=>
      RDATA[7] == $past(WDOG_EXPIRED))
    else $error("status top bit differs from watchdog state");
  AST_SET_READ_ZERO: assert property (
    RD && fn == axis_card_pkg::FN_SET |=> RDATA == '0)
    else $error("set value address read back non-zero");
  AST_SET_WRITE: assert property (
    (WR && fn == axis_card_pkg::FN_SET && !WDOG_EXPIRED) ##1 !WDOG_EXPIRED
      |-> SET_VALUE[$past(ADDR[4:3])] == $past(WDATA))
    else $error("set value not taken from write data");
  AST_SET_HOLD: assert property (
    !$past(WR) && !$past(WDOG_EXPIRED) |-> $stable(SET_VALUE))
    else $error("set value moved without write or expiry");
  AST_EXPIRY_CLEARS: assert property (
    WDOG_EXPIRED && $past(WDOG_EXPIRED) && WDOG_CLEARS_SET
      && $past(WDOG_CLEARS_SET, 3) |-> SET_VALUE == '0)
    else $error("set values not cleared while expired");
  AST_READ_RETRIGGERS: assert property (
    pos_rd && !WDOG_LATCHED |-> ##2 !WDOG_EXPIRED [*8])
    else $error("position read did not restart watchdog");
  AST_EXPIRES: assert property (
    idle_q >= WDOG_CYCLES + 4 && !WDOG_LATCHED |-> WDOG_EXPIRED)
    else $error("watchdog failed to expire without position reads");
  AST_NOT_EARLY: assert property (
    idle_q > 3 && idle_q + 4 < WDOG_CYCLES && !WDOG_LATCHED
      |-> !WDOG_EXPIRED)
    else $error("watchdog expired too early");
endmodule

bind axis_card_counter axis_card_counter_asserts #(
  .WDOG_CYCLES(WDOG_CYCLES)
) chk_u (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .WDOG_CLEARS_SET(WDOG_CLEARS_SET),
  .WDOG_LATCHED(WDOG_LATCHED), .SET_VALUE(SET_VALUE),
  .WDOG_EXPIRED(WDOG_EXPIRED)
);

/* File: sim/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input wire logic CLK,
  // register port
  output logic [axis_card_pkg::ADDR_W-1:0] ADDR,
  output logic [axis_card_pkg::DATA_W-1:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [axis_card_pkg::DATA_W-1:0] RDATA
);
  initial begin
    ADDR = '0;
    WDATA = '0;
    WR = 1'b0;
    RD = 1'b0;
  end

  // one strobe per call, so write and read never overlap
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    d = RDATA;
  endtask
endmodule

/* File: sim/test_axis_card_counter.sv */
`timescale 1ns/1ps
module test_axis_card_counter;
  localparam int WD = 50;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [4:0] ADDR;
  logic [15:0] WDATA, RDATA;
  logic WR, RD, WDOG_EXPIRED;
  // counter axis keeps track b at its enabling level from the start
  logic [3:0] TRACK_A = '0, TRACK_B = 4'h8, ZERO_PULSE = '0;
  logic TOUCH_PROBE_INPUT = 1'b0, PROBE_FALLING = 1'b0;
  logic WDOG_CLEARS_SET = 1'b1, WDOG_LATCHED = 1'b0;
  logic [3:0][1:0] EVAL_MODE = {2'h3, 2'h2, 2'h1, 2'h0};
  logic [3:0][15:0] SET_VALUE;
  int fail_count = 0, cmp_count = 0, ph = 0;
  logic b3 = 1'b1, up = 1'b1;

  always #10 CLK = ~CLK;

  axis_card_counter #(.WDOG_CYCLES(WD)) dut_u (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TRACK_A(TRACK_A), .TRACK_B(TRACK_B),
    .ZERO_PULSE(ZERO_PULSE), .TOUCH_PROBE_INPUT(TOUCH_PROBE_INPUT),
    .EVAL_MODE(EVAL_MODE), .PROBE_FALLING(PROBE_FALLING),
    .WDOG_CLEARS_SET(WDOG_CLEARS_SET), .WDOG_LATCHED(WDOG_LATCHED),
    .SET_VALUE(SET_VALUE), .WDOG_EXPIRED(WDOG_EXPIRED)
  );

  host_bus_model host_u (
    .CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] adr(input int ax, input logic [1:0] f);
    return {ax[1:0], f, 1'b0};
  endfunction

  // counter axis always counts up, one per a-track rise
  function automatic logic [15:0] fx(input int ax, input int n,
                                     input logic u);
    int m;
    m = (ax == 0) ? 4 : (ax == 1) ? 2 : 1;
    if (ax == 3) return n[15:0];
    return u ? 16'(m * n) : 16'(-(m * n));
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // whole quadrature cycles; slow enough for the pin synchronisers
  task automatic quad(input int n, input int dir);
    repeat (n * 4) begin
      ph = (ph + dir) & 3;
      @(posedge CLK);
      TRACK_A <= {4{ph == 1 || ph == 2}};
      TRACK_B <= {b3, {3{ph >= 2}}};
      cyc(4);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] v, s;
    logic [3:0][15:0] p;
    int n;
    void'($urandom(32'h32b155c4));
    cyc(12);
    RST_N <= 1'b1;
    for (int i = 0; i < 4; i++) host_u.rd(adr(i, 2'h1), v);
    for (int i = 0; i < 4; i++) host_u.rd(adr(i, 2'h3), v);
    // counting in all four multiplicities
    n = $urandom_range(5, 1);
    quad(n, 1);
    for (int i = 0; i < 4; i++) begin
      host_u.rd(adr(i, 2'h1), v);
      chk("count", fx(i, n, up), v);
    end
    for (int i = 0; i < 4; i++) begin
      host_u.rd(adr(i, 2'h1), v);
      chk("reread", (i == 3) ? 16'h0 : fx(i, n, up), v);
    end
    quad(n + 1, -1);
    for (int i = 0; i < 4; i++) begin
      host_u.rd(adr(i, 2'h1), v);
      chk("wrap", fx(i, (i == 3) ? n + 1 : 1, !up), v);
    end
    // counter axis: b moves alone, away from any a edge
    b3 = 1'b0;
    @(posedge CLK);
    TRACK_B[3] <= b3;
    cyc(4);
    quad(1, 1);
    b3 = 1'b1;
    @(posedge CLK);
    TRACK_B[3] <= b3;
    cyc(4);
    quad(1, 1);
    host_u.rd(adr(3, 2'h1), v);
    chk("stopped", 16'h0, v);
    quad(2, 1);
    host_u.rd(adr(3, 2'h1), v);
    chk("resumed", 16'h2, v);
    quad(3, 1);
    @(posedge CLK);
    ZERO_PULSE <= 4'hf;
    cyc(6);
    ZERO_PULSE <= 4'h0;
    host_u.rd(adr(3, 2'h1), v);
    chk("zero pulse", 16'h0, v);
    // set values and watchdog
    host_u.rd(adr(0, 2'h1), v);
    p = {16'($urandom), 16'h0000, 16'h8000, 16'h7fff};
    for (int i = 0; i < 4; i++) host_u.wr(adr(i, 2'h2), p[i]);
    cyc(1);
    for (int i = 0; i < 4; i++) chk("set", p[i], SET_VALUE[i]);
    repeat (WD / 4 + 3) host_u.rd(adr(1, 2'h3), v);
    host_u.rd(adr(0, 2'h0), v);
    chk("expired bit", 16'h80, v & 16'h80);
    chk("cleared set", 16'h0, SET_VALUE[0]);
    host_u.rd(adr(0, 2'h1), v);
    chk("retrigger", 16'h0, {15'h0, WDOG_EXPIRED});
    WDOG_CLEARS_SET <= 1'b0;
    s = 16'($urandom);
    host_u.wr(adr(1, 2'h2), s);
    cyc(WD + 10);
    chk("expired", 16'h1, {15'h0, WDOG_EXPIRED});
    chk("kept set", s, SET_VALUE[1]);
    // capture sequence
    host_u.wr(adr(2, 2'h0), 16'h0004);
    for (int i = 0; i < 4; i++) host_u.rd(adr(i, 2'h1), p[i]);
    TOUCH_PROBE_INPUT <= 1'b1;
    cyc(4);
    quad(1, 1);
    for (int i = 0; i < 4; i++) begin
      host_u.rd(adr(i, 2'h0), v);
      chk("ready", 16'h8, v & 16'h8);
    end
    host_u.rd(adr(0, 2'h1), v);
    chk("frozen", p[0], v);
    host_u.rd(adr(0, 2'h3), v);
    chk("captured", p[0], v);
    host_u.rd(adr(0, 2'h0), v);
    chk("ready clear", 16'h0, v & 16'h8);
    host_u.rd(adr(0, 2'h1), v);
    chk("released", p[0] + fx(0, 1, up), v);
    host_u.rd(adr(1, 2'h1), v);
    chk("still frozen", p[1], v);
    // probe still active: re-arm fires at once
    host_u.wr(adr(0, 2'h0), 16'h0004);
    cyc(4);
    host_u.rd(adr(1, 2'h3), v);
    chk("unread kept", p[1], v);
    host_u.rd(adr(0, 2'h3), v);
    chk("immediate", p[0] + fx(0, 1, up), v);
    for (int i = 2; i < 4; i++) host_u.rd(adr(i, 2'h3), v);
    // cancel before trigger
    TOUCH_PROBE_INPUT <= 1'b0;
    cyc(4);
    host_u.wr(adr(0, 2'h0), 16'h0004);
    host_u.rd(adr(2, 2'h3), v);
    TOUCH_PROBE_INPUT <= 1'b1;
    cyc(6);
    host_u.rd(adr(0, 2'h0), v);
    chk("cancelled", 16'h0, v & 16'h8);
    // falling polarity: high is now the idle level
    PROBE_FALLING <= 1'b1;
    cyc(4);
    host_u.wr(adr(1, 2'h0), 16'h0004);
    cyc(4);
    host_u.rd(adr(0, 2'h0), v);
    chk("idle level", 16'h0, v & 16'h8);
    TOUCH_PROBE_INPUT <= 1'b0;
    cyc(4);
    host_u.rd(adr(0, 2'h0), v);
    chk("falling", 16'h8, v & 16'h8);
    for (int i = 0; i < 4; i++) host_u.rd(adr(i, 2'h3), v);
    // reference movement on axis 0, position read afresh afterwards
    host_u.wr(adr(0, 2'h0), 16'h0001);
    @(posedge CLK);
    ZERO_PULSE <= 4'h1;
    cyc(6);
    ZERO_PULSE <= 4'h0;
    cyc(4);
    host_u.rd(adr(0, 2'h1), v);
    chk("reference", 16'h0, v);
    // latched watchdog: reads leave it set, a status write clears it
    WDOG_LATCHED <= 1'b1;
    cyc(4);
    host_u.wr(adr(0, 2'h0), 16'h0000);
    cyc(WD + 10);
    host_u.rd(adr(0, 2'h1), v);
    chk("latched", 16'h1, {15'h0, WDOG_EXPIRED});
    host_u.wr(adr(0, 2'h0), 16'h0000);
    cyc(1);
    chk("unlatched", 16'h0, {15'h0, WDOG_EXPIRED});
    stop_test();
  end
endmodule
